// ### hw/elic_exp_check.sv
/*
 * range check of a 16-bit two's-complement exponent word.
 * assumes the word is stable for the cycle it is sampled by the user.
 */
`default_nettype none

module elic_exp_check (
   // carrier
   elic_exp_if.checker_end ex
);

   logic [7:0] mid_bits;
   logic [7:0] mid_plus_one;
   logic       mid_all_ones;
   logic       low_zero;

   assign mid_bits     = ex.word[elic_pkg::OP_EXP_MSB:elic_pkg::OP_EXP_LSB];
   // carry through all eight bits proves they were all ones
   assign mid_plus_one = mid_bits + 8'h01;
   assign mid_all_ones = (mid_plus_one == 8'h00);
   assign low_zero     = (ex.word[elic_pkg::OP_LOW_MSB:0] == 7'h00);

   assign ex.operand_sign_flag       = ex.word[elic_pkg::OP_SIGN_BIT];
   assign ex.exponent_bits_zero_flag = (mid_bits == 8'h00);

   // 8-bit sum only; the upper bits are judged by the flags below
   assign ex.biased = ex.word[7:0] + elic_pkg::EXP_BIAS;

   // positive with any middle bit set exceeds 177 octal
   assign ex.overflow = !ex.operand_sign_flag && !ex.exponent_bits_zero_flag;

   // negative: middle not all ones, or the lone 177600 case
   assign ex.underflow = ex.operand_sign_flag &&
                         (ex.exponent_bits_zero_flag ||
                          !mid_all_ones ||
                          low_zero);

endmodule : elic_exp_check

`default_nettype wire

// ### hw/elic_exp_if.sv
/*
 * carrier between the sequencer and the exponent range checker.
 * assumes the checker is purely combinational.
 */
`default_nettype none

interface elic_exp_if;
   logic [15:0] word;
   logic [7:0]  biased;
   logic        operand_sign_flag;
   logic        exponent_bits_zero_flag;
   logic        overflow;
   logic        underflow;

   modport checker_end (
      input  word,
      output biased,
      output operand_sign_flag,
      output exponent_bits_zero_flag,
      output overflow,
      output underflow
   );

   modport user_end (
      output word,
      input  biased,
      input  operand_sign_flag,
      input  exponent_bits_zero_flag,
      input  overflow,
      input  underflow
   );
endinterface : elic_exp_if

`default_nettype wire

// ### hw/elic_pkg.sv
/*
 * constants and types shared by the exponent-load / integer-convert slice.
 * assumes a single 25 MHz clock and octal figures rendered as hex here.
 */
`default_nettype none

package elic_pkg;

   // ----------------------------------------------------------------
   // exponent field
   // ----------------------------------------------------------------
   localparam logic [7:0] EXP_BIAS     = 8'h80;   // excess 200 octal
   localparam logic [7:0] SHORT_EXP    = 8'h8F;   // 217 octal, 15 shifts
   localparam logic [7:0] LONG_EXP     = 8'h9F;   // 237 octal, 31 shifts
   localparam logic [7:0] ZERO_EXP     = 8'h00;

   // ----------------------------------------------------------------
   // operand word fields
   // ----------------------------------------------------------------
   localparam int OP_SIGN_BIT          = 15;
   localparam int OP_EXP_MSB           = 14;
   localparam int OP_EXP_LSB           = 7;
   localparam int OP_LOW_MSB           = 6;

   // ----------------------------------------------------------------
   // fraction register layout
   // ----------------------------------------------------------------
   localparam int FRAC_W               = 60;
   localparam int FRAC_SIGN_BIT        = 59;
   localparam int FRAC_NORM_BIT        = 58;
   localparam int FRAC_UPPER_LSB       = 44;  // upper 16 bits 59..44
   localparam int SHORT_LOAD_LSB       = 35;  // short int to 50..35
   localparam int LONG_LOAD_LSB        = 19;  // long int to 50..19
   localparam int ALIGN_SHIFT          = 9;   // bit 50 to bit 59
   localparam logic [59:0] SINGLE_MASK = 60'h7FF_FFF8_0000_0000;  // bits 58..35
   localparam logic [59:0] DOUBLE_MASK = 60'h7FF_FFFF_FFFF_FFF8;  // bits 58..3

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_WORD1,
      ST_WORD2,
      ST_ALIGN,
      ST_TEST,
      ST_ZCHK,
      ST_NEG,
      ST_NORM
   } elic_state_t;

endpackage : elic_pkg

`default_nettype wire

// ### hw/elic_top.sv
/*
 * exponent-load range check and integer-to-floating convert sequencer.
 * assumes the host issues one instruction at a time with its modes and
 * delivers the operand words in order, high word first for long integers.
 * after its operand words a convert runs a fixed three-step lead-in (align, test, zero check or negate), then one cycle per shift.
 * results and traps are one-cycle pulses; result fields hold until the next.
 */
// Behaviour
// - legal exponent word plus 200 to exponent
// - increment bits 14..07; zero means all ones
// - unfit exponent raises overflow or underflow trap
// - negative, some middle bit clear: underflow
// - word 177600 is illegal underflow
// - other all-ones-high negatives are legal
// - positive with middle bits set: overflow
// - sign and middle-zero flags give underflow
// - short integer 16 bits to 24/56 fraction
// - long integer is two words, either precision
// - short at bits 50..35, long 50..19
// - shift left nine, bit 50 to 59
// - initial exponent 217 short, 237 long
// - bit 59 clear: decrement integer, borrow means zero
// - no borrow: add one back, normalize
// - bit 59 set: negate, minus sign, normalize
// - shift left to bit 58, decrement exponent
`default_nettype none

module elic_top (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   // instruction from host
   input  wire logic        start,
   input  wire logic        load_exponent_instruction,
   input  wire logic        long_int_mode,
   input  wire logic        double_mode,
   output logic             busy,
   // operand words from host memory
   input  wire logic        operand_valid,
   input  wire logic [15:0] operand_data,
   output logic             operand_ready,
   // result to destination accumulator
   output logic             result_valid,
   output logic             result_zero,
   output logic             result_sign,
   output logic [7:0]       result_exp,
   output logic [59:0]      fraction_shift_register,
   // traps to host
   output logic             trap_overflow,
   output logic             trap_underflow
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      elic_pkg::elic_state_t st;
      logic                  is_load_exp;
      logic                  long_mode;
      logic                  dbl_mode;
      logic [15:0]           hi_word;
      logic [59:0]           frac;
      logic [7:0]            exp;
      logic                  sign;
      logic                  res_valid;
      logic                  res_zero;
      logic                  trap_ovf;
      logic                  trap_unf;
   } elic_regs_t;

   elic_regs_t r;
   elic_regs_t next_r;

   localparam elic_regs_t RESET_REGS = '{
      st:          elic_pkg::ST_IDLE,
      is_load_exp: 1'b0,
      long_mode:   1'b0,
      dbl_mode:    1'b0,
      hi_word:     16'h0000,
      frac:        60'h000_0000_0000_0000,
      exp:         elic_pkg::ZERO_EXP,
      sign:        1'b0,
      res_valid:   1'b0,
      res_zero:    1'b0,
      trap_ovf:    1'b0,
      trap_unf:    1'b0
   };

   // ----------------------------------------------------------------
   // exponent range checker
   // ----------------------------------------------------------------
   elic_exp_if ex ();

   assign ex.word = operand_data;

   elic_exp_check u_check (
      .ex (ex)
   );

   // ----------------------------------------------------------------
   // datapath helpers
   // ----------------------------------------------------------------
   logic [59:0] int_unit;
   logic [59:0] frac_dec;
   logic [59:0] frac_inc;
   logic [59:0] frac_neg;
   logic [59:0] frac_short;
   logic [59:0] frac_long;
   logic [59:0] frac_align;
   logic [59:0] frac_shl;
   logic [59:0] frac_shr;
   logic [7:0]  exp_dec;
   logic [7:0]  exp_inc;
   logic        is_neg;
   logic        is_normal;
   logic [59:0] prec_mask;

   // one at the integer's lsb: a long word with a zero high half must not borrow
   assign int_unit   = r.long_mode ? 60'h000_0000_0000_0001 << (elic_pkg::LONG_LOAD_LSB + elic_pkg::ALIGN_SHIFT)
                                   : 60'h000_0000_0000_0001 << elic_pkg::FRAC_UPPER_LSB;
   assign frac_dec   = r.frac - int_unit;
   assign frac_inc   = r.frac + int_unit;
   assign frac_neg   = ~r.frac + 60'h000_0000_0000_0001;
   assign frac_short = 60'(operand_data) << elic_pkg::SHORT_LOAD_LSB;
   assign frac_long  = 60'({r.hi_word, operand_data}) << elic_pkg::LONG_LOAD_LSB;
   assign frac_align = r.frac << elic_pkg::ALIGN_SHIFT;
   assign frac_shl   = r.frac << 1;
   assign frac_shr   = r.frac >> 1;
   assign exp_dec    = r.exp - 8'h01;
   assign exp_inc    = r.exp + 8'h01;
   assign is_neg     = r.frac[elic_pkg::FRAC_SIGN_BIT];
   assign is_normal  = !r.frac[elic_pkg::FRAC_SIGN_BIT] && r.frac[elic_pkg::FRAC_NORM_BIT];
   // truncation, not rounding: the low bits of the fraction are dropped
   assign prec_mask  = r.dbl_mode ? elic_pkg::DOUBLE_MASK : elic_pkg::SINGLE_MASK;

   assign busy          = (r.st != elic_pkg::ST_IDLE);
   assign operand_ready = (r.st == elic_pkg::ST_WORD1) || (r.st == elic_pkg::ST_WORD2);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // the struct, ports and masks are laid out for these positions only
   if (elic_pkg::FRAC_W != $bits(fraction_shift_register)) begin : g_frac_w
      $error("fraction width differs from the fraction port");
   end

   if (elic_pkg::FRAC_SIGN_BIT != elic_pkg::FRAC_W - 1) begin : g_sign
      $error("fraction sign bit is not the top bit");
   end

   if (elic_pkg::FRAC_NORM_BIT != elic_pkg::FRAC_SIGN_BIT - 1) begin : g_norm
      $error("normalize bit is not just below the sign bit");
   end

   if (elic_pkg::SHORT_LOAD_LSB + elic_pkg::ALIGN_SHIFT != elic_pkg::FRAC_UPPER_LSB) begin : g_short
      $error("short integer does not align to the upper sixteen bits");
   end

   if (elic_pkg::LONG_LOAD_LSB + 2 * $bits(operand_data) + elic_pkg::ALIGN_SHIFT != elic_pkg::FRAC_W) begin : g_long
      $error("long integer does not align to the top of the fraction");
   end

   if (elic_pkg::OP_EXP_MSB - elic_pkg::OP_EXP_LSB + 1 != $bits(result_exp)) begin : g_exp
      $error("operand exponent field does not fill the exponent");
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_r           = r;
      next_r.res_valid = 1'b0;
      next_r.trap_ovf  = 1'b0;
      next_r.trap_unf  = 1'b0;

      case (r.st)
         elic_pkg::ST_IDLE: begin
            if (start) begin
               // modes are latched here and held for the whole instruction
               next_r.is_load_exp = load_exponent_instruction;
               next_r.long_mode   = long_int_mode;
               next_r.dbl_mode    = double_mode;
               next_r.st          = elic_pkg::ST_WORD1;
            end
         end

         elic_pkg::ST_WORD1: begin
            if (operand_valid) begin
               if (r.is_load_exp) begin
                  if (ex.overflow || ex.underflow) begin
                     // exponent register is left untouched on a trap
                     next_r.trap_ovf = ex.overflow;
                     next_r.trap_unf = ex.underflow;
                  end else begin
                     next_r.exp       = ex.biased;
                     next_r.res_zero  = 1'b0;
                     next_r.res_valid = 1'b1;
                  end
                  next_r.st = elic_pkg::ST_IDLE;
               end else if (r.long_mode) begin
                  next_r.hi_word = operand_data;
                  next_r.st      = elic_pkg::ST_WORD2;
               end else begin
                  next_r.frac = frac_short;
                  next_r.exp  = elic_pkg::SHORT_EXP;
                  next_r.sign = 1'b0;
                  next_r.st   = elic_pkg::ST_ALIGN;
               end
            end
         end

         elic_pkg::ST_WORD2: begin
            if (operand_valid) begin
               next_r.frac = frac_long;
               next_r.exp  = elic_pkg::LONG_EXP;
               next_r.sign = 1'b0;
               next_r.st   = elic_pkg::ST_ALIGN;
            end
         end

         elic_pkg::ST_ALIGN: begin
            next_r.frac = frac_align;
            next_r.st   = elic_pkg::ST_TEST;
         end

         elic_pkg::ST_TEST: begin
            if (is_neg) begin
               next_r.st = elic_pkg::ST_NEG;
            end else begin
               next_r.frac = frac_dec;
               next_r.st = elic_pkg::ST_ZCHK;
            end
         end

         elic_pkg::ST_ZCHK: begin
            if (is_neg) begin
               // borrow rippled to the top: the integer was zero
               next_r.frac      = 60'h000_0000_0000_0000;
               next_r.exp       = elic_pkg::ZERO_EXP;
               next_r.sign      = 1'b0;
               next_r.res_zero  = 1'b1;
               next_r.res_valid = 1'b1;
               next_r.st        = elic_pkg::ST_IDLE;
            end else begin
               next_r.frac = frac_inc;
               next_r.st = elic_pkg::ST_NORM;
            end
         end

         elic_pkg::ST_NEG: begin
            next_r.frac = frac_neg;
            next_r.sign = 1'b1;
            next_r.st   = elic_pkg::ST_NORM;
         end

         elic_pkg::ST_NORM: begin
            if (is_neg) begin
               // only the most negative integer lands here after negation
               next_r.frac = frac_shr;
               next_r.exp  = exp_inc;
            end else if (!is_normal) begin
               // one place per cycle: worst case 30 cycles for long input
               next_r.frac = frac_shl;
               next_r.exp  = exp_dec;
            end else begin
               next_r.frac      = r.frac & prec_mask;
               next_r.res_zero  = 1'b0;
               next_r.res_valid = 1'b1;
               next_r.st        = elic_pkg::ST_IDLE;
            end
         end

         default: begin
            next_r = RESET_REGS;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= RESET_REGS;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign result_valid            = r.res_valid;
   assign result_zero             = r.res_zero;
   assign result_sign             = r.sign;
   assign result_exp              = r.exp;
   assign fraction_shift_register = r.frac;
   assign trap_overflow           = r.trap_ovf;
   assign trap_underflow          = r.trap_unf;

endmodule : elic_top

`default_nettype wire

// ### test/elic_host_model.sv
/* host memory model: hands operand words to the block in queue order.
   assumes the bench fills the queue before each instruction. */
`default_nettype none
module elic_host_model (
   // clock
   input  wire logic        ref_clk,
   // operand handshake
   input  wire logic        operand_ready,
   output var  logic        operand_valid,
   output var  logic [15:0] operand_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] words[$];
   int          stall  = 0;
   int          wait_n = 0;
   logic        taken  = 1'b0;
   initial begin
      operand_valid = 1'b0;
      operand_data  = 16'h0000;
   end
   always @(posedge ref_clk) taken <= operand_valid && operand_ready;
   // word held until taken, high word first
   always @(negedge ref_clk) begin
      if (taken) begin
         void'(words.pop_front());
         operand_valid = 1'b0;
         wait_n = stall;
      end
      if (!operand_valid && words.size() > 0 && wait_n == 0) begin
         operand_valid = 1'b1;
         operand_data  = words[0];
      end else if (!operand_valid) begin
         // released bus must not show a stale word
         operand_data = ~operand_data;
         if (wait_n > 0) wait_n--;
      end
   end
endmodule : elic_host_model
`default_nettype wire

// ### test/elic_top_asserts.sv
/* port assertions for the exponent-load / convert slice.
   assumes one clock and reset_n active low. */
`default_nettype none
module elic_top_asserts (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        reset_n,
   // instruction and operand
   input wire logic        start,
   input wire logic        load_exponent_instruction,
   input wire logic        long_int_mode,
   input wire logic        busy,
   input wire logic        operand_valid,
   input wire logic [15:0] operand_data,
   input wire logic        operand_ready,
   // results and traps
   input wire logic        result_valid,
   input wire logic        result_zero,
   input wire logic        result_sign,
   input wire logic [7:0]  result_exp,
   input wire logic [59:0] fraction_shift_register,
   input wire logic        trap_overflow,
   input wire logic        trap_underflow
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        le_m;
   logic        lg_m;
   logic        tk;
   logic [15:0] w;
   logic [7:0]  wl;
   assign tk = operand_valid && operand_ready;
   assign w  = operand_data;
   assign wl = operand_data[7:0];
   // modes as latched by a taken start
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         le_m <= 1'b0;
         lg_m <= 1'b0;
      end else if (start && !busy) begin
         le_m <= load_exponent_instruction;
         lg_m <= long_int_mode;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_exp_pos_add: assert property (le_m && tk && w[15:7] == 9'h000 |=>
      result_valid && result_exp == $past(wl) + 8'h80) else $error("positive exponent not committed");
   a_exp_neg_add: assert property (le_m && tk && (&w[15:7]) && (|w[6:0]) |=>
      result_valid && result_exp == $past(wl) + 8'h80) else $error("negative exponent not committed");
   a_exp_special: assert property (le_m && tk && w == 16'hFF80 |=>
      trap_underflow && !result_valid) else $error("special word not underflow");
   a_exp_neg_under: assert property (le_m && tk && w[15] && !(&w[14:7]) |=>
      trap_underflow && !trap_overflow) else $error("negative word not underflow");
   a_exp_pos_over: assert property (le_m && tk && !w[15] && (|w[14:7]) |=>
      trap_overflow && !trap_underflow) else $error("positive word not overflow");
   a_trap_no_commit: assert property (trap_overflow || trap_underflow |->
      !result_valid && $stable(result_exp)) else $error("trap committed an exponent");
   a_conv_norm: assert property (result_valid && !le_m && !result_zero |->
      fraction_shift_register[59:58] == 2'h1) else $error("fraction not normalized");
   a_conv_zero: assert property (result_valid && !le_m && result_zero |->
      result_exp == 8'h00 && fraction_shift_register == '0) else $error("zero result not clean");
   a_short_exp: assert property (result_valid && !le_m && !lg_m && !result_zero |->
      result_exp inside {[8'h81:8'h90]}) else $error("short exponent out of range");
   a_short_time: assert property (!le_m && !lg_m && tk |-> ##[3:22] result_valid)
      else $error("short convert too slow");
   a_start_ready: assert property (start && !busy |=> busy && operand_ready)
      else $error("start not answered with operand ready");
   c_underflow: cover property (trap_underflow);
   c_zero: cover property (result_valid && result_zero);
   c_negative: cover property (result_valid && result_sign && !le_m);
endmodule : elic_top_asserts
bind elic_top elic_top_asserts u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .start(start),
   .load_exponent_instruction(load_exponent_instruction), .long_int_mode(long_int_mode), .busy(busy),
   .operand_valid(operand_valid), .operand_data(operand_data), .operand_ready(operand_ready),
   .result_valid(result_valid), .result_zero(result_zero), .result_sign(result_sign),
   .result_exp(result_exp), .fraction_shift_register(fraction_shift_register),
   .trap_overflow(trap_overflow), .trap_underflow(trap_underflow));
`default_nettype wire

// ### test/exponent_load_int_convert_tb.sv
/* self-checking bench for the exponent-load / integer-convert slice.
   assumes elic_top, elic_pkg, the host model and the bound checker. */
`default_nettype none
module exponent_load_int_convert_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [2:0]  md;  // load exp, long, double
      logic [15:0] w0;
      logic [15:0] w1;
      logic [1:0]  kd;  // 0 value, 1 over, 2 under, 3 zero
      logic        sg;
      logic [7:0]  ex;
   } elic_row_t;
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        start = 1'b0;
   logic        le = 1'b0;
   logic        lg = 1'b0;
   logic        dbl = 1'b0;
   logic        busy, operand_valid, operand_ready, result_valid, result_zero, result_sign;
   logic        trap_overflow, trap_underflow;
   logic [15:0] operand_data;
   logic [7:0]  result_exp;
   logic [59:0] fraction_shift_register;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          cycles = 0;
   // ------------------------------------------------------------
   // rows: traps expect the last committed exponent to remain
   // ------------------------------------------------------------
   elic_row_t rows [22] = '{
      '{3'h4, 16'h0001, 16'h0000, 2'h0, 1'h0, 8'h81}, '{3'h4, 16'h007F, 16'h0000, 2'h0, 1'h0, 8'hFF},
      '{3'h4, 16'h0000, 16'h0000, 2'h0, 1'h0, 8'h80}, '{3'h4, 16'hFF81, 16'h0000, 2'h0, 1'h0, 8'h01},
      '{3'h4, 16'hFFFF, 16'h0000, 2'h0, 1'h0, 8'h7F}, '{3'h4, 16'hFF80, 16'h0000, 2'h2, 1'h0, 8'h7F},
      '{3'h4, 16'h8000, 16'h0000, 2'h2, 1'h0, 8'h7F}, '{3'h4, 16'hFE7F, 16'h0000, 2'h2, 1'h0, 8'h7F},
      '{3'h4, 16'h0080, 16'h0000, 2'h1, 1'h0, 8'h7F}, '{3'h4, 16'h7FFF, 16'h0000, 2'h1, 1'h0, 8'h7F},
      '{3'h0, 16'h0001, 16'h0000, 2'h0, 1'h0, 8'h81}, '{3'h0, 16'h0081, 16'h0000, 2'h0, 1'h0, 8'h88},
      '{3'h0, 16'h0000, 16'h0000, 2'h3, 1'h0, 8'h00}, '{3'h0, 16'hFFFF, 16'h0000, 2'h0, 1'h1, 8'h81},
      '{3'h0, 16'h8000, 16'h0000, 2'h0, 1'h1, 8'h90}, '{3'h1, 16'h7FFF, 16'h0000, 2'h0, 1'h0, 8'h8F},
      '{3'h1, 16'hFF7F, 16'h0000, 2'h0, 1'h1, 8'h88}, '{3'h2, 16'h0001, 16'h0000, 2'h0, 1'h0, 8'h91},
      '{3'h3, 16'hFFFF, 16'hFFFE, 2'h0, 1'h1, 8'h82}, '{3'h2, 16'h8000, 16'h0000, 2'h0, 1'h1, 8'hA0},
      '{3'h3, 16'h0000, 16'h0000, 2'h3, 1'h0, 8'h00}, '{3'h3, 16'h7FFF, 16'hFFFF, 2'h0, 1'h0, 8'h9F}};
   elic_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .start(start), .load_exponent_instruction(le),
      .long_int_mode(lg), .double_mode(dbl), .busy(busy), .operand_valid(operand_valid),
      .operand_data(operand_data), .operand_ready(operand_ready), .result_valid(result_valid),
      .result_zero(result_zero), .result_sign(result_sign), .result_exp(result_exp),
      .fraction_shift_register(fraction_shift_register), .trap_overflow(trap_overflow),
      .trap_underflow(trap_underflow));
   elic_host_model host (.ref_clk(ref_clk), .operand_ready(operand_ready), .operand_valid(operand_valid),
      .operand_data(operand_data));
   always #20 ref_clk = ~ref_clk;
   task automatic stop_test();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // magnitude normalized to bit 58, truncated to the precision
   function automatic logic [59:0] exp_frac(input elic_row_t r);
      logic [31:0] v;
      logic [32:0] m;
      int          k;
      v = r.md[1] ? {r.w0, r.w1} : {{16{r.w0[15]}}, r.w0};
      m = v[31] ? {1'b0, ~v} + 33'h1 : {1'b0, v};
      k = 0;
      for (int i = 0; i < 32; i++) if (m[i]) k = i;
      return (60'(m) << (58 - k)) & (r.md[0] ? elic_pkg::DOUBLE_MASK : elic_pkg::SINGLE_MASK);
   endfunction : exp_frac
   task automatic run_row(input elic_row_t r);
      int n;
      host.words.push_back(r.w0);
      if (r.md[1] && !r.md[2]) host.words.push_back(r.w1);
      start = 1'b1;
      le = r.md[2];
      lg = r.md[1];
      dbl = r.md[0];
      @(negedge ref_clk);
      start = 1'b0;
      n = 0;
      while (!(result_valid || trap_overflow || trap_underflow) && n < 60) begin
         @(negedge ref_clk);
         n++;
      end
      chk("valid", result_valid, r.kd == 2'h0 || r.kd == 2'h3);
      chk("over", trap_overflow, r.kd == 2'h1);
      chk("under", trap_underflow, r.kd == 2'h2);
      chk("exp", result_exp, r.ex);
      if (!r.md[2]) begin
         chk("sign", result_sign, r.sg);
         chk("zero", result_zero, r.kd == 2'h3);
         chk("frac", fraction_shift_register, exp_frac(r));
      end
   endtask : run_row
   // ------------------------------------------------------------
   // main sequence, then hand-written cases
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(negedge ref_clk);
      chk("busy", busy, 1'h0);
      chk("exp", result_exp, 8'h00);
      reset_n = 1'b1;
      @(negedge ref_clk);
      foreach (rows[i]) run_row(rows[i]);
      // slow host, and a start while busy must be ignored
      host.stall = 3;
      fork
         run_row('{3'h2, 16'h0000, 16'h0081, 2'h0, 1'h0, 8'h88});
         begin
            repeat (2) @(negedge ref_clk);
            start = 1'b1;
            le = 1'b1;
            @(negedge ref_clk);
            start = 1'b0;
         end
      join
      // reset in mid-convert
      host.stall = 0;
      host.words.push_back(16'h0081);
      le = 1'b0;
      lg = 1'b0;
      start = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
      repeat (2) @(negedge ref_clk);
      reset_n = 1'b0;
      @(negedge ref_clk);
      chk("busy", busy, 1'h0);
      chk("valid", result_valid, 1'h0);
      chk("ready", operand_ready, 1'h0);
      host.words.delete();
      reset_n = 1'b1;
      @(negedge ref_clk);
      run_row(rows[11]);
      stop_test();
   end
endmodule : exponent_load_int_convert_tb
`default_nettype wire
